// ==== rtl/rtcuac_defines.svh ====
// Register offsets, reset values and timing constants of the clock core
`ifndef RTCUAC_DEFINES_SVH
`define RTCUAC_DEFINES_SVH
`define RTCUAC_OFF_SEC 7'h00
`define RTCUAC_OFF_SEC_AL 7'h01
`define RTCUAC_OFF_MIN 7'h02
`define RTCUAC_OFF_MIN_AL 7'h03
`define RTCUAC_OFF_HR 7'h04
`define RTCUAC_OFF_HR_AL 7'h05
`define RTCUAC_OFF_WDAY 7'h06
`define RTCUAC_OFF_DOM 7'h07
`define RTCUAC_OFF_MON 7'h08
`define RTCUAC_OFF_YEAR 7'h09
`define RTCUAC_OFF_CTLA 7'h0A
`define RTCUAC_OFF_CTLB 7'h0B
`define RTCUAC_OFF_FLAGS 7'h0C
`define RTCUAC_OFF_CTLD 7'h0D
`define RTCUAC_OFF_STD_IDX 7'h7E
`define RTCUAC_OFF_EXT_IDX 7'h7F
`define RTCUAC_CLOCK_BYTES 8'h0E
`define RTCUAC_FCLK_HZ 32'h0000_8000
`define RTCUAC_TOGGLE_HZ 32'h0001_0000
`define RTCUAC_US_PER_S 32'h000F_4240
`define RTCUAC_BUC_US 32'h0000_00F4
`define RTCUAC_PRE_LAST 15'h7FFF
`define RTCUAC_PRE_START 15'h4000
`define RTCUAC_OSC_RUN 2'h1
`define RTCUAC_CENTURY_BIT_PIVOT 8'h50
`define RTCUAC_WILD_HMS 2'h3
`define RTCUAC_STATE_RST '0
`endif

// ==== rtl/rtcuac_pkg.sv ====
// Types shared by the clock core: control B byte layout, time bytes and core state
`default_nettype none
package rtcuac_pkg;
    typedef struct packed {
        logic update_hold;
        logic periodic_irq_en;
        logic aie;
        logic update_irq_en;
        logic rsv;
        logic df;
        logic hf;
        logic dse;
    } rtcuac_ctlb_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
        logic [7:0] wday;
        logic [7:0] dom;
        logic [7:0] mon;
        logic [7:0] yr;
    } rtcuac_time_t;

    typedef struct packed {
        rtcuac_time_t t;
        rtcuac_time_t u;
        logic [7:0] al_sec;
        logic [7:0] al_min;
        logic [7:0] al_hr;
        logic [5:0] al_dom;
        logic [2:0] osc;
        logic [3:0] rs;
        rtcuac_ctlb_t b;
        logic pend;
        logic irq_summary_flag;
        logic pf;
        logic af;
        logic uf;
        logic century;
        logic [6:0] std_idx;
        logic [6:0] ext_idx;
        logic as_p;
        logic ds_p;
        logic [14:0] pre;
        logic [31:0] acc;
        logic fclk;
        logic [7:0] ad;
        logic ad_oe;
        logic irq_n;
        logic irq_oe;
    } rtcuac_state_t;
endpackage
`default_nettype wire

// ==== rtl/rtcuac_core.sv ====
// Clock/calendar core with update cycle, alarm, periodic event and host bus
`default_nettype none
`include "rtcuac_defines.svh"
module rtcuac_core
    import rtcuac_pkg::*;
#(
    parameter int unsigned CLK_HZ = 200_000_000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Multiplexed host bus
    input wire logic [7:0] i_ad,
    output logic [7:0] o_ad,
    output logic o_ad_oe,
    input wire logic i_cs_n,
    input wire logic i_addr_strobe,
    input wire logic i_data_strobe,
    input wire logic i_rd_wr_n,
    input wire logic i_upper_bank_sel,
    // Open-drain interrupt request, active low
    output logic o_irq_n,
    output logic o_irq_n_oe,
    // Fixed 32.768 kHz output
    output logic o_fixed_clock_out
);
    localparam int unsigned BUC_TICKS =
        (`RTCUAC_BUC_US * `RTCUAC_FCLK_HZ + `RTCUAC_US_PER_S - 1) / `RTCUAC_US_PER_S;
    localparam logic [14:0] PEND_AT = 15'(`RTCUAC_FCLK_HZ - BUC_TICKS);

    if (CLK_HZ < 2 * `RTCUAC_TOGGLE_HZ) begin : g_chk
        $error("CLK_HZ too low for the 32.768 kHz timebase");
    end

    rtcuac_state_t q, n;
    logic [7:0] mem [0:255];
    logic as_fall, ds_fall, wr, rd_drive, rd_end, bank, tick, run, upd, req;
    logic al_match;
    logic [6:0] addr;
    logic [7:0] rdata, wdata;
    logic [31:0] acc_sum;
    logic [14:0] pmask;

    function automatic logic [7:0] enc(input logic [7:0] v, input logic bin);
        logic [7:0] tens;
        tens = v / 8'h0A;
        enc = bin ? v : ((tens << 4) | (v % 8'h0A));
    endfunction

    function automatic logic [7:0] dec(input logic [7:0] v, input logic bin);
        dec = bin ? v : (v[7:4] * 8'h0A + {4'h0, v[3:0]});
    endfunction

    function automatic logic [7:0] enc_hr(input logic [7:0] h, input logic bin,
                                          input logic h24);
        logic [7:0] h12;
        logic [7:0] e;
        h12 = (h == 8'h00) ? 8'h0C : (h > 8'h0C) ? h - 8'h0C : h;
        e = enc(h12, bin);
        enc_hr = h24 ? enc(h, bin) : {h >= 8'h0C, e[6:0]};
    endfunction

    function automatic logic [7:0] dec_hr(input logic [7:0] v, input logic bin,
                                          input logic h24);
        logic [7:0] t;
        t = dec({1'b0, v[6:0]}, bin);
        if (h24) begin
            dec_hr = dec(v, bin);
        end else if (t == 8'h0C) begin
            dec_hr = v[7] ? 8'h0C : 8'h00;
        end else begin
            dec_hr = v[7] ? t + 8'h0C : t;
        end
    endfunction

    function automatic logic [7:0] mdays(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02: mdays = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: mdays = 8'h1E;
            default: mdays = 8'h1F;
        endcase
    endfunction

    function automatic logic [14:0] per_mask(input logic [3:0] rs);
        logic [3:0] k;
        k = (rs == 4'h1) ? 4'h7 : (rs == 4'h2) ? 4'h8 : rs - 4'h1;
        per_mask = (15'h0001 << k) - 15'h0001;
    endfunction

    function automatic rtcuac_time_t encode_all(input rtcuac_time_t t,
                                                input rtcuac_ctlb_t b);
        encode_all.sec = enc(t.sec, b.df);
        encode_all.min = enc(t.min, b.df);
        encode_all.hr = enc_hr(t.hr, b.df, b.hf);
        encode_all.wday = t.wday;
        encode_all.dom = enc(t.dom, b.df);
        encode_all.mon = enc(t.mon, b.df);
        encode_all.yr = enc(t.yr, b.df);
    endfunction

    // Host read data
    always_comb begin
        rdata = 8'h00;
        if (bank) begin
            if (addr == `RTCUAC_OFF_EXT_IDX) begin
                rdata = {q.century, q.ext_idx};
            end else begin
                rdata = mem[{1'b1, addr}];
            end
        end else if (addr == `RTCUAC_OFF_SEC) begin
            rdata = q.u.sec;
        end else if (addr == `RTCUAC_OFF_SEC_AL) begin
            rdata = q.al_sec;
        end else if (addr == `RTCUAC_OFF_MIN) begin
            rdata = q.u.min;
        end else if (addr == `RTCUAC_OFF_MIN_AL) begin
            rdata = q.al_min;
        end else if (addr == `RTCUAC_OFF_HR) begin
            rdata = q.u.hr;
        end else if (addr == `RTCUAC_OFF_HR_AL) begin
            rdata = q.al_hr;
        end else if (addr == `RTCUAC_OFF_WDAY) begin
            rdata = q.u.wday;
        end else if (addr == `RTCUAC_OFF_DOM) begin
            rdata = q.u.dom;
        end else if (addr == `RTCUAC_OFF_MON) begin
            rdata = q.u.mon;
        end else if (addr == `RTCUAC_OFF_YEAR) begin
            rdata = q.u.yr;
        end else if (addr == `RTCUAC_OFF_CTLA) begin
            rdata = {q.pend, q.osc, q.rs};
        end else if (addr == `RTCUAC_OFF_CTLB) begin
            rdata = q.b;
        end else if (addr == `RTCUAC_OFF_FLAGS) begin
            rdata = {q.irq_summary_flag, q.pf, q.af, q.uf, 4'h0};
        end else if (addr == `RTCUAC_OFF_CTLD) begin
            rdata = {2'h2, q.al_dom};
        end else if (addr == `RTCUAC_OFF_STD_IDX) begin
            rdata = {1'b0, q.std_idx};
        end else begin
            rdata = mem[{1'b0, addr}];
        end
    end

    // Storage bytes outside the clock bytes
    always_ff @(posedge i_clk) begin
        if (wr && (bank ? (addr != `RTCUAC_OFF_EXT_IDX)
                        : ({1'b0, addr} >= `RTCUAC_CLOCK_BYTES)
                          && (addr != `RTCUAC_OFF_STD_IDX))) begin
            mem[{bank, addr}] <= wdata;
        end
    end

    always_comb begin
        n = q;
        bank = i_upper_bank_sel;
        addr = bank ? q.ext_idx : q.std_idx;
        wdata = i_ad;
        as_fall = q.as_p & ~i_addr_strobe;
        ds_fall = q.ds_p & ~i_data_strobe;
        wr = ds_fall & ~i_cs_n & ~i_rd_wr_n;
        rd_drive = ~i_cs_n & i_data_strobe & i_rd_wr_n;
        rd_end = ds_fall & ~i_cs_n & i_rd_wr_n;
        n.as_p = i_addr_strobe;
        n.ds_p = i_data_strobe;

        // Address phase
        if (as_fall) begin
            if (i_upper_bank_sel) begin
                n.ext_idx = i_ad[6:0];
            end else begin
                n.std_idx = i_ad[6:0];
            end
        end

        // Flag read clears before new events so an event this cycle survives
        if (rd_end && !bank && addr == `RTCUAC_OFF_FLAGS) begin
            n.irq_summary_flag = 1'b0;
            n.pf = 1'b0;
            n.af = 1'b0;
            n.uf = 1'b0;
        end

        // Host writes; clock bytes valid only with bank select low
        if (wr && !bank) begin
            if (addr == `RTCUAC_OFF_SEC) begin
                n.t.sec = dec(wdata, q.b.df);
                n.u.sec = wdata;
            end else if (addr == `RTCUAC_OFF_SEC_AL) begin
                n.al_sec = wdata;
            end else if (addr == `RTCUAC_OFF_MIN) begin
                n.t.min = dec(wdata, q.b.df);
                n.u.min = wdata;
            end else if (addr == `RTCUAC_OFF_MIN_AL) begin
                n.al_min = wdata;
            end else if (addr == `RTCUAC_OFF_HR) begin
                n.t.hr = dec_hr(wdata, q.b.df, q.b.hf);
                n.u.hr = wdata;
            end else if (addr == `RTCUAC_OFF_HR_AL) begin
                n.al_hr = wdata;
            end else if (addr == `RTCUAC_OFF_WDAY) begin
                n.t.wday = wdata;
                n.u.wday = wdata;
            end else if (addr == `RTCUAC_OFF_DOM) begin
                n.t.dom = dec(wdata, q.b.df);
                n.u.dom = wdata;
            end else if (addr == `RTCUAC_OFF_MON) begin
                n.t.mon = dec(wdata, q.b.df);
                n.u.mon = wdata;
            end else if (addr == `RTCUAC_OFF_YEAR) begin
                n.t.yr = dec(wdata, q.b.df);
                n.u.yr = wdata;
                n.century = n.t.yr < `RTCUAC_CENTURY_BIT_PIVOT;
            end else if (addr == `RTCUAC_OFF_CTLA) begin
                n.osc = wdata[6:4];
                n.rs = wdata[3:0];
            end else if (addr == `RTCUAC_OFF_CTLB) begin
                n.b = wdata;
            end else if (addr == `RTCUAC_OFF_CTLD) begin
                n.al_dom = wdata[5:0];
            end
        end
        n.b.rsv = 1'b0;
        if (n.b.update_hold) begin
            n.b.update_irq_en = 1'b0;
        end

        // Fixed clock: fractional divider, free of all control bits
        acc_sum = q.acc + `RTCUAC_TOGGLE_HZ;
        tick = 1'b0;
        if (acc_sum >= 32'(CLK_HZ)) begin
            n.acc = acc_sum - 32'(CLK_HZ);
            n.fclk = ~q.fclk;
            tick = q.fclk;
        end else begin
            n.acc = acc_sum;
        end

        // Divider chain runs only for oscillator patterns 010 and 011
        run = q.osc[2:1] == `RTCUAC_OSC_RUN;
        upd = run & tick & (q.pre == `RTCUAC_PRE_LAST);
        if (!run) begin
            n.pre = `RTCUAC_PRE_START;
            n.pend = 1'b0;
        end else if (tick) begin
            n.pre = q.pre + 15'h0001;
        end

        // Periodic event
        pmask = per_mask(q.rs);
        if (run && tick && q.rs != 4'h0 && (q.pre & pmask) == pmask) begin
            n.pf = 1'b1;
        end

        if (run && q.pre >= PEND_AT && !upd) begin
            n.pend = 1'b1;
        end

        // Update cycle
        al_match = 1'b0;
        if (upd) begin
            n.t.sec = n.t.sec + 8'h01;
            if (n.t.sec > 8'h3B) begin
                n.t.sec = 8'h00;
                n.t.min = n.t.min + 8'h01;
                if (n.t.min > 8'h3B) begin
                    n.t.min = 8'h00;
                    n.t.hr = n.t.hr + 8'h01;
                    if (n.t.hr > 8'h17) begin
                        n.t.hr = 8'h00;
                        n.t.wday = (n.t.wday >= 8'h07) ? 8'h01 : n.t.wday + 8'h01;
                        n.t.dom = n.t.dom + 8'h01;
                        if (n.t.dom > mdays(n.t.mon, n.t.yr)) begin
                            n.t.dom = 8'h01;
                            n.t.mon = n.t.mon + 8'h01;
                            if (n.t.mon > 8'h0C) begin
                                n.t.mon = 8'h01;
                                n.t.yr = n.t.yr + 8'h01;
                                if (n.t.yr > 8'h63) begin
                                    n.t.yr = 8'h00;
                                    n.century = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
            if (!n.b.update_hold) begin
                n.u = encode_all(n.t, n.b);
            end
            al_match =
                ((n.al_sec[7:6] == `RTCUAC_WILD_HMS) || n.al_sec == enc(n.t.sec, n.b.df))
                && ((n.al_min[7:6] == `RTCUAC_WILD_HMS)
                    || n.al_min == enc(n.t.min, n.b.df))
                && ((n.al_hr[7:6] == `RTCUAC_WILD_HMS)
                    || n.al_hr == enc_hr(n.t.hr, n.b.df, n.b.hf))
                && ((n.al_dom == 6'h00)
                    || {2'h0, n.al_dom} == enc(n.t.dom, n.b.df));
            if (al_match) begin
                n.af = 1'b1;
            end
            n.uf = 1'b1;
            n.pend = 1'b0;
        end
        if (n.b.update_hold) begin
            n.pend = 1'b0;
        end

        // Request and summary flag
        req = (n.pf & n.b.periodic_irq_en) | (n.af & n.b.aie)
            | (n.uf & n.b.update_irq_en & ~n.b.update_hold);
        if (req) begin
            n.irq_summary_flag = 1'b1;
        end
        n.irq_oe = req;
        n.irq_n = ~req;

        // Data phase drive
        n.ad_oe = rd_drive;
        n.ad = rd_drive ? rdata : 8'h00;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= `RTCUAC_STATE_RST;
        end else begin
            q <= n;
        end
    end

    assign o_ad = q.ad;
    assign o_ad_oe = q.ad_oe;
    assign o_irq_n = q.irq_n;
    assign o_irq_n_oe = q.irq_oe;
    assign o_fixed_clock_out = q.fclk;
endmodule
`default_nettype wire

// ==== test/rtcuac_core_asserts.sv ====
// Port-level concurrent checks for the clock core
`default_nettype none
module rtcuac_core_asserts #(
    parameter int unsigned CLK_HZ = 200_000_000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Host bus
    input wire logic [7:0] i_ad,
    input wire logic [7:0] o_ad,
    input wire logic o_ad_oe,
    input wire logic i_cs_n,
    input wire logic i_addr_strobe,
    input wire logic i_data_strobe,
    input wire logic i_rd_wr_n,
    input wire logic i_upper_bank_sel,
    // Request pin and fixed clock
    input wire logic o_irq_n,
    input wire logic o_irq_n_oe,
    input wire logic o_fixed_clock_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FCLK_MAX = CLK_HZ / 65536 + 1;
    logic as_q;
    logic ds_q;
    logic fclk_q;
    logic [6:0] std_addr_q;
    logic [31:0] fclk_cnt_q;
    logic flag_rd;

    // Shadow of the standard address latch and fixed clock half-period
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            as_q <= 1'b0;
            ds_q <= 1'b0;
            fclk_q <= 1'b0;
            std_addr_q <= 7'h00;
            fclk_cnt_q <= 32'h0;
        end else begin
            as_q <= i_addr_strobe;
            ds_q <= i_data_strobe;
            fclk_q <= o_fixed_clock_out;
            fclk_cnt_q <= (o_fixed_clock_out != fclk_q) ? 32'h0 : fclk_cnt_q + 32'h1;
            if (as_q && !i_addr_strobe && !i_upper_bank_sel) begin
                std_addr_q <= i_ad[6:0];
            end
        end
    end
    assign flag_rd = ds_q && !i_data_strobe && !i_cs_n && i_rd_wr_n && !i_upper_bank_sel
        && std_addr_q == 7'h0C;

    a_irq_pin_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_irq_n_oe |-> !o_irq_n) else $error("request enabled but pin level high");
    a_flag_read_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        flag_rd |=> !o_irq_n_oe) else $error("request kept after flag read");
    a_summary_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        flag_rd && $past(o_irq_n_oe, 2) |-> o_ad[7]) else $error("summary flag missing");
    a_read_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_cs_n && i_data_strobe && i_rd_wr_n |=> o_ad_oe) else $error("read not driven");
    a_read_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_data_strobe |=> !o_ad_oe) else $error("bus held after strobe low");
    a_drive_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_ad_oe) |-> $past(i_rd_wr_n) && !$past(i_cs_n) && $past(i_data_strobe))
        else $error("bus driven without read");
    a_idle_bus_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_ad_oe |-> o_ad == 8'h00) else $error("read data not zero when idle");
    a_fixed_clk_runs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        fclk_cnt_q <= FCLK_MAX) else $error("fixed clock output stalled");
endmodule
bind rtcuac_core rtcuac_core_asserts #(.CLK_HZ(CLK_HZ)) u_asserts (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_ad(i_ad), .o_ad(o_ad), .o_ad_oe(o_ad_oe), .i_cs_n(i_cs_n),
    .i_addr_strobe(i_addr_strobe), .i_data_strobe(i_data_strobe), .i_rd_wr_n(i_rd_wr_n),
    .i_upper_bank_sel(i_upper_bank_sel), .o_irq_n(o_irq_n), .o_irq_n_oe(o_irq_n_oe),
    .o_fixed_clock_out(o_fixed_clock_out));
`default_nettype wire

// ==== test/rtcuac_host.sv ====
// Host processor model for the multiplexed address/data bus
`default_nettype none
module rtcuac_host (
    // Clock
    input wire logic i_clk,
    // Resolved bus level
    input wire logic [7:0] i_rd_data,
    // Bus controls
    output logic [7:0] o_ad,
    output logic o_cs_n,
    output logic o_addr_strobe,
    output logic o_data_strobe,
    output logic o_rd_wr_n,
    output logic o_upper_bank_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_ad = 8'hA5;
        o_cs_n = 1'b1;
        o_addr_strobe = 1'b0;
        o_data_strobe = 1'b0;
        o_rd_wr_n = 1'b1;
        o_upper_bank_sel = 1'b0;
    end

    task automatic addr_phase(input logic [6:0] a, input logic bk);
        @(posedge i_clk);
        o_addr_strobe <= 1'b1;
        o_ad <= {1'b0, a};
        o_upper_bank_sel <= bk;
        @(posedge i_clk);
        o_addr_strobe <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] a, input logic bk, input logic [7:0] v);
        addr_phase(a, bk);
        @(posedge i_clk);
        o_data_strobe <= 1'b1;
        o_rd_wr_n <= 1'b0;
        o_cs_n <= 1'b0;
        o_ad <= v;
        repeat (2) @(posedge i_clk);
        o_data_strobe <= 1'b0;
        @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_rd_wr_n <= 1'b1;
        o_ad <= ~v;
    endtask

    task automatic rd(input logic [6:0] a, input logic bk, output logic [7:0] v);
        addr_phase(a, bk);
        @(posedge i_clk);
        o_data_strobe <= 1'b1;
        o_cs_n <= 1'b0;
        o_ad <= ~o_ad;
        repeat (2) @(posedge i_clk);
        v = i_rd_data;
        o_data_strobe <= 1'b0;
        @(posedge i_clk);
        o_cs_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== test/rtcuac_core_tb.sv ====
// Self-checking bench for the clock core
`default_nettype none
`define CHK(nm, exp, got) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
end
module rtcuac_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned CLK_HZ = 131072;
    logic clk;
    logic rst_n;
    logic [7:0] host_ad;
    logic [7:0] bus_ad;
    logic [7:0] dut_ad;
    logic dut_ad_oe;
    logic cs_n;
    logic as_s;
    logic ds_s;
    logic rw_n;
    logic bank;
    logic irq_n;
    logic irq_oe;
    logic fclk;
    logic [7:0] d;
    int errors;
    int num_checks;
    int cycles;
    int n;
    logic [6:0] set_a [11] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
        7'h08, 7'h09, 7'h0D};
    // Minute and day alarms exact, seconds and hours alarms wildcard
    logic [7:0] set_v [11] = '{8'h3B, 8'hC0, 8'h3B, 8'h00, 8'h17, 8'hC0, 8'h07, 8'h1F,
        8'h0C, 8'h63, 8'h01};
    logic [7:0] rb_v [11] = '{8'h3B, 8'hC0, 8'h3B, 8'h00, 8'h17, 8'hC0, 8'h07, 8'h1F,
        8'h0C, 8'h63, 8'h81};
    logic [7:0] upd_v [11] = '{8'h00, 8'hC0, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h01, 8'h01,
        8'h01, 8'h00, 8'h81};

    assign bus_ad = dut_ad_oe ? dut_ad : host_ad;

    rtcuac_core #(.CLK_HZ(CLK_HZ)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_ad(bus_ad),
        .o_ad(dut_ad), .o_ad_oe(dut_ad_oe), .i_cs_n(cs_n), .i_addr_strobe(as_s),
        .i_data_strobe(ds_s), .i_rd_wr_n(rw_n), .i_upper_bank_sel(bank), .o_irq_n(irq_n),
        .o_irq_n_oe(irq_oe), .o_fixed_clock_out(fclk));
    rtcuac_host u_host (.i_clk(clk), .i_rd_data(bus_ad), .o_ad(host_ad), .o_cs_n(cs_n),
        .o_addr_strobe(as_s), .o_data_strobe(ds_s), .o_rd_wr_n(rw_n),
        .o_upper_bank_sel(bank));

    always #2.5 clk = ~clk;

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        `CHK("irq enable", 1'b0, irq_oe)
        u_host.rd(7'h0C, 1'b0, d);
        `CHK("flags", 8'h00, d)
        u_host.rd(7'h0B, 1'b0, d);
        `CHK("control b", 8'h00, d & 8'h78)
        // Fixed clock toggles with the oscillator bits still off
        n = 0;
        d[0] = fclk;
        repeat (64) begin
            @(posedge clk);
            if (fclk !== d[0]) n++;
            d[0] = fclk;
        end
        `CHK("fixed clock edges", 64 * 65536 / CLK_HZ, n)
        $display("reset test done");
        u_host.wr(7'h0B, 1'b0, 8'h86);
        u_host.wr(7'h09, 1'b0, 8'h10);
        u_host.rd(7'h7F, 1'b1, d);
        `CHK("century low year", 8'hFF, d)
        foreach (set_a[i]) u_host.wr(set_a[i], 1'b0, set_v[i]);
        foreach (set_a[i]) begin
            u_host.rd(set_a[i], 1'b0, d);
            `CHK("time byte", rb_v[i], d)
        end
        u_host.rd(7'h7F, 1'b1, d);
        `CHK("century high year", 8'h7F, d)
        $display("program test done");
        u_host.wr(7'h0B, 1'b0, 8'h16);
        u_host.wr(7'h0A, 1'b0, 8'h20);
        n = 0;
        do begin
            u_host.rd(7'h0A, 1'b0, d);
            n++;
        end while (d[7] !== 1'b1 && n < 12000);
        `CHK("pending", 8'hA0, d)
        `CHK("irq before update", 1'b0, irq_oe)
        n = 0;
        while (irq_oe !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
        `CHK("irq after update", 1'b1, irq_oe)
        `CHK("irq pin", 1'b0, irq_n)
        u_host.rd(7'h0C, 1'b0, d);
        `CHK("update flags", 8'hB0, d)
        u_host.rd(7'h0C, 1'b0, d);
        `CHK("flags cleared", 8'h00, d)
        `CHK("irq released", 1'b0, irq_oe)
        u_host.rd(7'h0A, 1'b0, d);
        `CHK("pending cleared", 8'h20, d)
        foreach (set_a[i]) begin
            u_host.rd(set_a[i], 1'b0, d);
            `CHK("rolled byte", upd_v[i], d)
        end
        u_host.wr(7'h7F, 1'b1, 8'h00);
        u_host.rd(7'h7F, 1'b1, d);
        `CHK("century rollover", 8'hFF, d)
        $display("update test done");
        u_host.wr(7'h0A, 1'b0, 8'h33);
        u_host.wr(7'h0B, 1'b0, 8'h46);
        n = 0;
        while (irq_oe !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        `CHK("periodic irq", 1'b1, irq_oe)
        u_host.wr(7'h0B, 1'b0, 8'h06);
        u_host.wr(7'h0A, 1'b0, 8'h30);
        u_host.rd(7'h0C, 1'b0, d);
        `CHK("periodic flags", 8'hC0, d)
        repeat (80) @(posedge clk);
        u_host.rd(7'h0C, 1'b0, d);
        `CHK("rate off flags", 8'h00, d)
        `CHK("rate off irq", 1'b0, irq_oe)
        $display("periodic test done");
        // Year 79 in decimal coding lies below the pivot, 0x79 binary does not
        u_host.wr(7'h0B, 1'b0, 8'h02);
        u_host.wr(7'h09, 1'b0, 8'h79);
        u_host.rd(7'h7F, 1'b1, d);
        `CHK("century bcd year", 8'hFF, d)
        $display("bcd century test done");
        test_done();
    end
endmodule
`default_nettype wire
